// ---- hw/gate_clamp_params.svh ----
// Offsets, field positions, reset values and timing counts of the block
`ifndef GATE_CLAMP_PARAMS_SVH
`define GATE_CLAMP_PARAMS_SVH
`define OFS_TURN_ON_GATE_MONITOR 5'h1d
`define OFS_CLAMP_ACTIVATION_TIME 5'h1e
`define OFS_SECONDARY_CLOCK_CHECK 5'h1f
`define RST_TURN_ON_GATE_MONITOR 16'hff01
`define RST_CLAMP_ACTIVATION_TIME 16'h2600
`define RST_SECONDARY_CLOCK_CHECK 16'h0001
`define RST_CLAMP_TIME 8'h26
`define RST_TURN_ON_COUNT 8'hff
`define FLD_HI_MSB 15
`define FLD_HI_LSB 8
`define BIT_ARMED 7
`define BIT_LMI 1
`define BIT_PARITY 0
`define CLAMP_CONST_HIGH 8'h00
`define CLAMP_CONST_LOW 8'hff
`define CLAMP_MIN_TIMED 8'h0a
`define CNT_MAX 8'hff
`define CNT_ONE 8'h01
`endif

// ---- hw/gate_clamp_pkg.sv ----
// Types shared by the gate timing and clamp register block
`default_nettype none
package gate_clamp_pkg;
   typedef enum logic [2:0] {
      OPM_ONE, OPM_TWO, OPM_THREE, OPM_FOUR, OPM_FIVE, OPM_SIX
   } op_mode_t;
   typedef enum {CAP_IDLE, CAP_ARMED, CAP_COUNT} cap_state_t;
endpackage : gate_clamp_pkg
`default_nettype wire

// ---- hw/word_parity.sv ----
// Odd parity completion of a returned register word
`timescale 1ns/1ns
`default_nettype none
module word_parity (
   input wire logic [15:1] word_hi,
   output logic parity_bit
);
   // Bit 0 chosen so the full word carries an odd number of ones
   assign parity_bit = ~(^word_hi);
endmodule : word_parity
`default_nettype wire

// ---- hw/gate_timing_clamp_regs.sv ----
// Turn-on gate timing capture, clamp-inhibit timing and clock check regs
//
// Summary of operation
// - Turn-on gate pulse length is counted into bits 15:8 of the monitor.
// - Turn-on count is cleared to zero when a measurement starts.
// - Bit 7 of the monitor reads one while capture is armed.
// - Arm bit clears when the turn-on measurement completes.
// - A capture request while armed disarms instead of rearming.
// - Bit 1 of each returned word: previous frame discarded when one.
// - Clamp codes 0A..FE give activation time in oscillator cycles.
// - Clamp code 00 holds the clamp-inhibit output constantly high.
// - Clamp code FF holds the clamp-inhibit output constantly low.
// - Clock check writes measured oscillator cycles into bits 15:8.
// - Clamp register writable only in mode two; others never writable.
`timescale 1ns/1ns
`default_nettype none
`include "gate_clamp_params.svh"
module gate_timing_clamp_regs (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic msg_done,
   input wire logic msg_invalid,
   input wire gate_clamp_pkg::op_mode_t config_operating_mode,
   input wire logic osc_tick,
   input wire logic capture_request,
   input wire logic gate_on,
   input wire logic clamp_trigger,
   input wire logic clock_check_function,
   output logic [15:0] reg_rdata,
   output logic reg_hit,
   output logic turn_on_capture_armed,
   output logic clamp_inhibit_out
);
   gate_clamp_pkg::cap_state_t cap_q;
   logic [7:0] turn_on_count_q;
   logic [7:0] clamp_time_value_q;
   logic [7:0] measured_osc_cycles_q;
   logic [7:0] osc_count_q;
   logic check_q;
   logic last_msg_invalid_q;
   logic [7:0] clamp_cnt_q;
   logic clamp_active_q;
   logic gate_on_q;
   logic [15:0] word_d;
   logic [15:0] rdata_q;
   logic parity_bit;
   logic gate_rise;
   logic write_clamp;
   logic clamp_code_high;
   logic clamp_code_low;
   logic check_start;
   logic check_end;

   // Frame status; reset word shows zero here in monitor reset value
   always_ff @(posedge mclk) begin
      if (reset) begin
         last_msg_invalid_q <= 1'b0;
      end else if (msg_done) begin
         last_msg_invalid_q <= msg_invalid;
      end
   end

   // Turn-on capture; gate sampled once to find the start edge; end taken from gate level
   always_ff @(posedge mclk) begin
      if (reset) begin
         gate_on_q <= 1'b0;
      end else begin
         gate_on_q <= gate_on;
      end
   end

   // Rising edge only; a gate already high when armed starts nothing
   assign gate_rise = gate_on && !gate_on_q;

   always_ff @(posedge mclk) begin
      if (reset) begin
         cap_q <= gate_clamp_pkg::CAP_IDLE;
         turn_on_count_q <= `RST_TURN_ON_COUNT;
      end else begin
         case (cap_q)
            gate_clamp_pkg::CAP_IDLE: begin
               if (capture_request) begin
                  cap_q <= gate_clamp_pkg::CAP_ARMED;
               end
            end
            gate_clamp_pkg::CAP_ARMED: begin
               if (capture_request) begin
                  cap_q <= gate_clamp_pkg::CAP_IDLE;
               end else if (gate_rise) begin
                  turn_on_count_q <= 8'h00;
                  cap_q <= gate_clamp_pkg::CAP_COUNT;
               end
            end
            gate_clamp_pkg::CAP_COUNT: begin
               if (capture_request) begin
                  cap_q <= gate_clamp_pkg::CAP_IDLE;
               end else if (!gate_on) begin
                  cap_q <= gate_clamp_pkg::CAP_IDLE;
               // Saturates so an overlong pulse reads full scale
               end else if (osc_tick && turn_on_count_q != `CNT_MAX) begin
                  turn_on_count_q <= turn_on_count_q + `CNT_ONE;
               end
            end
            default: cap_q <= gate_clamp_pkg::CAP_IDLE;
         endcase
      end
   end

   assign turn_on_capture_armed = (cap_q != gate_clamp_pkg::CAP_IDLE);

   // Writes to the read-only registers or outside mode two are dropped
   assign write_clamp = reg_wr &&
                        (reg_addr == `OFS_CLAMP_ACTIVATION_TIME) &&
                        (config_operating_mode == gate_clamp_pkg::OPM_TWO);

   // Clamp time register: only mode two writes land
   always_ff @(posedge mclk) begin
      if (reset) begin
         clamp_time_value_q <= `RST_CLAMP_TIME;
      end else if (write_clamp) begin
         clamp_time_value_q <= reg_wdata[`FLD_HI_MSB:`FLD_HI_LSB];
      end
   end

   // Timed pulse; reserved codes 01..09 are treated like short times
   always_ff @(posedge mclk) begin
      if (reset) begin
         clamp_cnt_q <= 8'h00;
         clamp_active_q <= 1'b0;
      end else if (clamp_trigger) begin
         clamp_cnt_q <= clamp_time_value_q;
         clamp_active_q <= 1'b1;
      end else if (clamp_active_q && osc_tick) begin
         if (clamp_cnt_q <= `CNT_ONE) begin
            clamp_active_q <= 1'b0;
         end
         clamp_cnt_q <= clamp_cnt_q - `CNT_ONE;
      end
   end

   // Constant codes override any timed pulse still counting
   assign clamp_code_high = (clamp_time_value_q == `CLAMP_CONST_HIGH);
   assign clamp_code_low = (clamp_time_value_q == `CLAMP_CONST_LOW);

   always_ff @(posedge mclk) begin
      if (reset) begin
         clamp_inhibit_out <= 1'b0;
      end else if (clamp_code_high) begin
         clamp_inhibit_out <= 1'b1;
      end else if (clamp_code_low) begin
         clamp_inhibit_out <= 1'b0;
      end else begin
         clamp_inhibit_out <= clamp_active_q;
      end
   end

   // Window edges; a window shorter than one tick measures zero
   assign check_start = clock_check_function && !check_q;
   assign check_end = !clock_check_function && check_q;

   // Clock check counts oscillator ticks while the check window is open
   always_ff @(posedge mclk) begin
      if (reset) begin
         check_q <= 1'b0;
         osc_count_q <= 8'h00;
         measured_osc_cycles_q <= 8'h00;
      end else begin
         check_q <= clock_check_function;
         if (check_start) begin
            osc_count_q <= 8'h00;
         end else if (clock_check_function && osc_tick &&
                      osc_count_q != `CNT_MAX) begin
            osc_count_q <= osc_count_q + `CNT_ONE;
         end
         if (check_end) begin
            measured_osc_cycles_q <= osc_count_q;
         end
      end
   end

   // Read word assembly; reserved bits forced to zero
   always_comb begin
      word_d = 16'h0000;
      case (reg_addr)
         `OFS_TURN_ON_GATE_MONITOR: begin
            word_d[`FLD_HI_MSB:`FLD_HI_LSB] = turn_on_count_q;
            word_d[`BIT_ARMED] = turn_on_capture_armed;
         end
         `OFS_CLAMP_ACTIVATION_TIME: begin
            word_d[`FLD_HI_MSB:`FLD_HI_LSB] = clamp_time_value_q;
         end
         `OFS_SECONDARY_CLOCK_CHECK: begin
            word_d[`FLD_HI_MSB:`FLD_HI_LSB] = measured_osc_cycles_q;
         end
         default: word_d = 16'h0000;
      endcase
      word_d[`BIT_LMI] = last_msg_invalid_q;
   end

   word_parity u_parity (
      .word_hi(word_d[15:1]),
      .parity_bit(parity_bit)
   );

   assign reg_hit = (reg_addr == `OFS_TURN_ON_GATE_MONITOR) ||
                    (reg_addr == `OFS_CLAMP_ACTIVATION_TIME) ||
                    (reg_addr == `OFS_SECONDARY_CLOCK_CHECK);

   always_ff @(posedge mclk) begin
      if (reset) begin
         // Idle word: fields zero, parity alone makes it odd
         rdata_q <= 16'h0001;
      end else if (reg_rd) begin
         rdata_q <= {word_d[15:1], parity_bit};
      end
   end

   assign reg_rdata = rdata_q;
endmodule : gate_timing_clamp_regs
`default_nettype wire

// ---- verification/gate_clamp_assertions.sv ----
// Assertions on the returned words and capture arming of the block
`timescale 1ns/1ns
`default_nettype none
module gate_clamp_assertions (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [4:0] reg_addr,
   input wire logic reg_rd,
   input wire logic msg_done,
   input wire logic msg_invalid,
   input wire logic capture_request,
   input wire logic gate_on,
   input wire logic [15:0] reg_rdata,
   input wire logic turn_on_capture_armed
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_bad_frame;
      msg_done && msg_invalid ##2 reg_rd;
   endsequence
   a_parity_odd: assert property (^reg_rdata)
      else $error("even parity word");
   a_reserved_zero: assert property (reg_rdata[6:2] == 5'h00)
      else $error("reserved bits set");
   a_arm_request: assert property (capture_request && !gate_on &&
      !turn_on_capture_armed |=> turn_on_capture_armed) else $error("no arm");
   a_rearm_disarms: assert property (capture_request &&
      turn_on_capture_armed |=> !turn_on_capture_armed) else $error("rearmed");
   a_armed_bit: assert property (reg_rd && reg_addr == 5'h1d |=>
      reg_rdata[7] == $past(turn_on_capture_armed)) else $error("bit 7");
   a_bit7_clear: assert property (reg_rd && reg_addr != 5'h1d |=>
      !reg_rdata[7]) else $error("bit 7 set");
   a_word_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("word changed");
   a_discard_flag: assert property (s_bad_frame |=> reg_rdata[1])
      else $error("discard not shown");
endmodule : gate_clamp_assertions
bind gate_timing_clamp_regs gate_clamp_assertions chk_u (
   .mclk(mclk),
   .reset(reset),
   .reg_addr(reg_addr),
   .reg_rd(reg_rd),
   .msg_done(msg_done),
   .msg_invalid(msg_invalid),
   .capture_request(capture_request),
   .gate_on(gate_on),
   .reg_rdata(reg_rdata),
   .turn_on_capture_armed(turn_on_capture_armed)
);
`default_nettype wire

// ---- verification/host_model.sv ----
// Host model sending one register frame per call
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input wire logic mclk,
   output logic [4:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic msg_done,
   output logic msg_invalid
);
   initial {reg_addr, reg_wdata, reg_wr, reg_rd, msg_done, msg_invalid} = '0;
   task automatic acc(logic w, logic [4:0] a, logic [15:0] d, logic i);
      @(negedge mclk) {reg_wr, reg_rd} = {w, !w};
      {reg_addr, reg_wdata} = {a, d};
      @(negedge mclk) {reg_wr, reg_rd, msg_done, msg_invalid} = {3'b001, i};
      // Released lines flip so stale values cannot pass
      {reg_addr, reg_wdata} = ~{a, d};
      @(negedge mclk) msg_done = 1'b0;
   endtask : acc
endmodule : host_model
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the gate timing and clamp register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
   bad_count++; $display("Error %s exp %h got %h", n, e, a); end end
module tb;
   logic mclk = 0, reset = 1, osc_tick = 0, capture_request = 0, gate_on = 0;
   logic clamp_trigger = 0, clock_check_function = 0, reg_wr, reg_rd, reg_hit;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic msg_done, msg_invalid, turn_on_capture_armed, clamp_inhibit_out;
   gate_clamp_pkg::op_mode_t config_operating_mode = gate_clamp_pkg::OPM_ONE;
   int bad_count = 0, samples_checked = 0, cyc = 0;
   gate_timing_clamp_regs dut_u (
      .mclk(mclk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .msg_done(msg_done),
      .msg_invalid(msg_invalid),
      .config_operating_mode(config_operating_mode),
      .osc_tick(osc_tick),
      .capture_request(capture_request),
      .gate_on(gate_on),
      .clamp_trigger(clamp_trigger),
      .clock_check_function(clock_check_function),
      .reg_rdata(reg_rdata),
      .reg_hit(reg_hit),
      .turn_on_capture_armed(turn_on_capture_armed),
      .clamp_inhibit_out(clamp_inhibit_out)
   );
   host_model host_u (
      .mclk(mclk),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .msg_done(msg_done),
      .msg_invalid(msg_invalid)
   );
   always #5 mclk = ~mclk;
   function automatic logic [15:0] odd(logic [15:0] v);
      return {v[15:1], ~^v[15:1]};
   endfunction : odd
   task automatic ticks(int n);
      repeat (n) begin
         @(negedge mclk) osc_tick = 1;
         @(negedge mclk) osc_tick = 0;
      end
   endtask : ticks
   task automatic rd(logic [4:0] a, logic [15:0] e, logic i);
      fork
         host_u.acc(1'b0, a, '0, i);
         begin
            @(negedge mclk);
            #2 `CHK("hit", 1'b1, reg_hit)
         end
      join
      `CHK("word", e, reg_rdata)
      `CHK("miss", 1'b0, reg_hit)
   endtask : rd
   task automatic t_capture;
      @(negedge mclk) capture_request = 1;
      @(negedge mclk) capture_request = 1;
      @(negedge mclk) capture_request = 1;
      @(negedge mclk) capture_request = 0;
      `CHK("armed", 1'b1, turn_on_capture_armed)
      rd(5'h1d, odd(16'hff80), 1'b0);
      @(negedge mclk) gate_on = 1;
      ticks(5);
      @(negedge mclk) gate_on = 0;
      rd(5'h1d, odd(16'h0500), 1'b1);
      rd(5'h1d, odd(16'h0502), 1'b0);
   endtask : t_capture
   task automatic t_clamp;
      host_u.acc(1'b1, 5'h1e, 16'h0c00, 1'b0);
      rd(5'h1e, 16'h2600, 1'b0);
      config_operating_mode = gate_clamp_pkg::OPM_TWO;
      host_u.acc(1'b1, 5'h1e, 16'h0c00, 1'b0);
      @(negedge mclk) clamp_trigger = 1;
      @(negedge mclk) clamp_trigger = 0;
      ticks(11);
      `CHK("pulse held", 1'b1, clamp_inhibit_out)
      ticks(2);
      `CHK("pulse end", 1'b0, clamp_inhibit_out)
      host_u.acc(1'b1, 5'h1e, 16'h0000, 1'b0);
      `CHK("const high", 1'b1, clamp_inhibit_out)
      host_u.acc(1'b1, 5'h1e, 16'hff00, 1'b0);
      `CHK("const low", 1'b0, clamp_inhibit_out)
      @(negedge mclk) clamp_trigger = 1;
      @(negedge mclk) clamp_trigger = 0;
      ticks(2);
      `CHK("low held", 1'b0, clamp_inhibit_out)
      host_u.acc(1'b1, 5'h1d, 16'h0000, 1'b0);
      rd(5'h1d, odd(16'h0500), 1'b0);
      rd(5'h1e, odd(16'hff00), 1'b0);
   endtask : t_clamp
   task automatic t_clock;
      @(negedge mclk) clock_check_function = 1;
      ticks(3);
      rd(5'h1f, odd(16'h0000), 1'b0);
      @(negedge mclk) clock_check_function = 0;
      rd(5'h1f, odd(16'h0300), 1'b0);
   endtask : t_clock
   task automatic end_sim;
      $display("Checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      repeat (3) @(negedge mclk);
      reset = 0;
      rd(5'h1d, 16'hff01, 1'b0);
      rd(5'h1f, 16'h0001, 1'b0);
      t_capture();
      t_clamp();
      t_clock();
      end_sim();
   end
endmodule : tb
`default_nettype wire
